//--- rtl/pcrc_top.sv
// Programmable CRC generator: Wishbone registers, data FIFO, 2-bit/cycle engine.
// Assumes a single 200 MHz clock, synchronous active-low reset, and an
// external idle-mode level input.
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pcrc_defines.svh"

module pcrc_top (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  // Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [5:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // System
  input  wire logic        i_sys_idle,
  output logic             o_irq
);

  pcrc_pkg::pcrc_cfg_t  cfg_r;
  pcrc_pkg::pcrc_state_t state_r;
  logic        on_r;
  logic        go_r;
  logic [15:0] xorl_r;
  logic [15:0] xorh_r;
  logic [15:0] datl_r;
  logic [15:0] dath_r;
  logic [31:0] res_r;
  logic [31:0] fifo_mem [`PCRC_FIFO_WORDS];
  logic [`PCRC_PTR_W-1:0] wr_ptr_r;
  logic [`PCRC_PTR_W-1:0] rd_ptr_r;
  logic [4:0]  vw_r;
  logic [31:0] buf_r;
  logic [4:0]  bits_left_r;
  logic [2:0]  idle_sync_r;
  logic        idle_q_r;

  // Depth as a function of data width
  function automatic logic [4:0] depth_of(input logic [4:0] dw);
    if (dw > `PCRC_DW_WIDE)
      depth_of = `PCRC_DEPTH_WIDE;
    else if (dw > `PCRC_DW_MID)
      depth_of = `PCRC_DEPTH_MID;
    else
      depth_of = `PCRC_DEPTH_NARROW;
  endfunction : depth_of

  // One LFSR step of a length-(pl+1) polynomial
  function automatic logic [31:0] crc_step(input logic [31:0] crc,
                                           input logic        din,
                                           input logic [31:0] poly,
                                           input logic [4:0]  pl);
    logic        fb;
    logic [31:0] sh;
    fb = crc[pl] ^ din;
    sh = {crc[30:0], 1'b0};
    if (fb)
      sh = sh ^ poly;
    crc_step = sh & ((32'h0000_0002 << pl) - 32'h0000_0001);
  endfunction : crc_step

  logic        bus_req;
  logic        wr_req;
  logic [3:0]  widx;
  logic [4:0]  depth;
  logic        full;
  logic        empty;
  logic        running;
  logic        push;
  logic        pop;
  logic        top_in_high;
  logic [31:0] poly;
  logic [31:0] word_mask;
  logic        done;
  logic [31:0] c1_rd;

  assign bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr_req  = bus_req && i_wb_we;
  assign widx    = i_wb_adr[5:2];
  assign depth   = depth_of(cfg_r.data_width_sel);
  assign full    = (vw_r == depth);
  assign empty   = (vw_r == 5'h00);
  assign running = on_r && !(cfg_r.idle_halt && idle_q_r);
  assign top_in_high = cfg_r.data_width_sel[4];
  // Bit 0 forced, top term implied by the feedback tap
  assign poly = {xorh_r, xorl_r[15:1], 1'b1};
  assign word_mask = (32'h0000_0002 << cfg_r.data_width_sel) - 32'h0000_0001;
  // Word counted on the write of DATH when wide, of DATL when narrow; full FIFO drops it
  assign push = running && wr_req && !full &&
                (top_in_high ? (widx == `PCRC_OFF_DATH) : (widx == `PCRC_OFF_DATL));
  assign pop  = running && go_r && state_r == pcrc_pkg::PCRC_IDLE && !empty;
  // Done on the step that consumes the last one or two bits of the last word
  assign done = state_r == pcrc_pkg::PCRC_SHIFT && bits_left_r <= 5'h01 && empty && go_r;

  // Bus answer: one wait-free ack, dropped the cycle after
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n)
      o_wb_ack <= 1'b0;
    else
      o_wb_ack <= bus_req;
  end

  always_comb begin
    c1_rd = `PCRC_ZERO32;
    c1_rd[`PCRC_C1_ON] = on_r;
    c1_rd[`PCRC_C1_IDLE] = cfg_r.idle_halt;
    c1_rd[`PCRC_C1_VW_HI:`PCRC_C1_VW_LO] = vw_r;
    c1_rd[`PCRC_C1_FULL] = full;
    c1_rd[`PCRC_C1_EMPTY] = empty;
    c1_rd[`PCRC_C1_ISEL] = cfg_r.irq_cond_sel;
    c1_rd[`PCRC_C1_GO] = go_r;
    c1_rd[`PCRC_C1_LSB] = cfg_r.lsb_first_sel;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n)
      o_wb_dat <= `PCRC_ZERO32;
    else if (bus_req && !i_wb_we) begin
      unique case (widx)
        `PCRC_OFF_CTRL1: o_wb_dat <= c1_rd;
        `PCRC_OFF_CTRL2: o_wb_dat <= {19'h00000, cfg_r.data_width_sel, 3'h0,
                                      cfg_r.poly_length_sel};
        `PCRC_OFF_XORL:  o_wb_dat <= {16'h0000, xorl_r};
        `PCRC_OFF_XORH:  o_wb_dat <= {16'h0000, xorh_r};
        `PCRC_OFF_DATL:  o_wb_dat <= {16'h0000, datl_r};
        `PCRC_OFF_DATH:  o_wb_dat <= {16'h0000, dath_r};
        `PCRC_OFF_RESL:  o_wb_dat <= {16'h0000, res_r[15:0]};
        `PCRC_OFF_RESH:  o_wb_dat <= {16'h0000, res_r[31:16]};
        default:         o_wb_dat <= `PCRC_ZERO32;
      endcase
    end
  end

  // Configuration survives module-off
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cfg_r  <= '0;
      on_r   <= 1'b0;
      xorl_r <= `PCRC_ZERO16;
      xorh_r <= `PCRC_ZERO16;
    end else if (wr_req) begin
      if (widx == `PCRC_OFF_CTRL1 && i_wb_sel[1]) begin
        on_r <= i_wb_dat[`PCRC_C1_ON];
        cfg_r.idle_halt <= i_wb_dat[`PCRC_C1_IDLE];
      end
      if (widx == `PCRC_OFF_CTRL1 && i_wb_sel[0]) begin
        cfg_r.irq_cond_sel  <= i_wb_dat[`PCRC_C1_ISEL];
        cfg_r.lsb_first_sel <= i_wb_dat[`PCRC_C1_LSB];
      end
      if (widx == `PCRC_OFF_CTRL2 && i_wb_sel[1])
        cfg_r.data_width_sel <= i_wb_dat[`PCRC_C2_DW_HI:`PCRC_C2_DW_LO];
      if (widx == `PCRC_OFF_CTRL2 && i_wb_sel[0])
        cfg_r.poly_length_sel <= i_wb_dat[`PCRC_C2_PL_HI:`PCRC_C2_PL_LO];
      if (widx == `PCRC_OFF_XORL)
        xorl_r <= i_wb_dat[15:0] & `PCRC_XORL_MASK;
      if (widx == `PCRC_OFF_XORH)
        xorh_r <= i_wb_dat[15:0];
    end
  end

  // Data holding pair; byte lanes let the held low half of a wide word be written a byte at a time
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || !on_r) begin
      datl_r <= `PCRC_ZERO16;
      dath_r <= `PCRC_ZERO16;
    end else if (wr_req && running) begin
      if (widx == `PCRC_OFF_DATL) begin
        if (i_wb_sel[0]) datl_r[7:0]  <= i_wb_dat[7:0];
        if (i_wb_sel[1]) datl_r[15:8] <= i_wb_dat[15:8];
      end
      if (widx == `PCRC_OFF_DATH) begin
        if (i_wb_sel[0]) dath_r[7:0]  <= i_wb_dat[7:0];
        if (i_wb_sel[1]) dath_r[15:8] <= i_wb_dat[15:8];
      end
    end
  end

  // FIFO storage: a wide pushed word merges the fresh top half with the held low half; a narrow one is the fresh half alone
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      if (top_in_high)
        fifo_mem[wr_ptr_r] <= {i_wb_dat[15:0], datl_r} & word_mask;
      else
        fifo_mem[wr_ptr_r] <= {16'h0000, i_wb_dat[15:0]} & word_mask;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || !on_r) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      vw_r     <= 5'h00;
    end else begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 4'h1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 4'h1;
      if (push && !pop)
        vw_r <= vw_r + 5'h01;
      else if (pop && !push)
        vw_r <= vw_r - 5'h01;
    end
  end

  // Idle level from outside: three flops, act when the last two agree
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      idle_sync_r <= 3'h0;
      idle_q_r    <= 1'b0;
    end else begin
      idle_sync_r <= {idle_sync_r[1:0], i_sys_idle};
      if (idle_sync_r[1] == idle_sync_r[2])
        idle_q_r <= idle_sync_r[2];
    end
  end

  // Shift engine
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || !on_r) begin
      state_r     <= pcrc_pkg::PCRC_IDLE;
      buf_r       <= `PCRC_ZERO32;
      bits_left_r <= 5'h00;
    end else if (running) begin
      unique case (state_r)
        pcrc_pkg::PCRC_IDLE: begin
          if (pop) begin
            buf_r       <= fifo_mem[rd_ptr_r];
            bits_left_r <= cfg_r.data_width_sel;
            state_r     <= pcrc_pkg::PCRC_SHIFT;
          end
        end
        pcrc_pkg::PCRC_SHIFT: begin
          if (bits_left_r <= 5'h01) begin
            state_r <= pcrc_pkg::PCRC_IDLE;
          end else begin
            bits_left_r <= bits_left_r - 5'h02;
            // MSb first walks the bit index down, so the word itself stays put
            if (cfg_r.lsb_first_sel)
              buf_r <= buf_r >> 2;
          end
        end
        default: state_r <= pcrc_pkg::PCRC_IDLE;
      endcase
    end
  end

  // Current and next input bits in the chosen order
  logic din0;
  logic din1;
  assign din0 = cfg_r.lsb_first_sel ? buf_r[0] : buf_r[bits_left_r];
  assign din1 = cfg_r.lsb_first_sel ? buf_r[1] : buf_r[bits_left_r - 5'h01];

  // Result: software can preload it to resume a halted run
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || !on_r)
      res_r <= `PCRC_ZERO32;
    else if (wr_req && widx == `PCRC_OFF_RESL)
      res_r[15:0] <= i_wb_dat[15:0];
    else if (wr_req && widx == `PCRC_OFF_RESH)
      res_r[31:16] <= i_wb_dat[15:0];
    else if (running && state_r == pcrc_pkg::PCRC_SHIFT) begin
      if (bits_left_r == 5'h00)
        res_r <= crc_step(res_r, din0, poly, cfg_r.poly_length_sel);
      else
        res_r <= crc_step(crc_step(res_r, din0, poly, cfg_r.poly_length_sel),
                          din1, poly, cfg_r.poly_length_sel);
    end
  end

  // Go bit: set by software, cleared by hardware at the end of the last word
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || !on_r)
      go_r <= 1'b0;
    else if (running && done)
      go_r <= 1'b0;
    else if (wr_req && widx == `PCRC_OFF_CTRL1 && i_wb_sel[0])
      go_r <= i_wb_dat[`PCRC_C1_GO];
  end

  // Interrupt pulse, one cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || !on_r)
      o_irq <= 1'b0;
    else if (cfg_r.irq_cond_sel)
      o_irq <= running && done;
    else
      o_irq <= pop && !push && vw_r == 5'h01;
  end

  // A word leaves the FIFO and the engine starts on it next cycle with bits_left_r at data_width_sel
  sequence s_word_load;
    state_r == pcrc_pkg::PCRC_IDLE && pop;
  endsequence : s_word_load

  sequence s_word_shift;
    state_r == pcrc_pkg::PCRC_SHIFT && bits_left_r == cfg_r.data_width_sel;
  endsequence : s_word_shift

  property p_count_bound;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      vw_r <= depth;
  endproperty : p_count_bound
  a_count_bound: assert property (p_count_bound) else $error("count above depth");

  property p_ack_pulse;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      o_wb_ack |=> !o_wb_ack;
  endproperty : p_ack_pulse
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_off_clears;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      !on_r |=> vw_r == 5'h00 && res_r == `PCRC_ZERO32 && !go_r;
  endproperty : p_off_clears
  a_off_clears: assert property (p_off_clears) else $error("module off kept state");

  property p_full_hold;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      full |=> vw_r <= $past(vw_r);
  endproperty : p_full_hold
  a_full_hold: assert property (p_full_hold) else $error("count rose while full");

  property p_word_load;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      s_word_load |=> s_word_shift;
  endproperty : p_word_load
  a_word_load: assert property (p_word_load) else $error("word load did not start");

  property p_irq_empty;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      !cfg_r.irq_cond_sel && pop && !push && vw_r == 5'h01 |=> o_irq;
  endproperty : p_irq_empty
  a_irq_empty: assert property (p_irq_empty) else $error("no interrupt at count zero");

  property p_irq_sw_clear;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      cfg_r.irq_cond_sel && !done |=> !o_irq;
  endproperty : p_irq_sw_clear
  a_irq_sw_clear: assert property (p_irq_sw_clear) else $error("interrupt without done");

  property p_go_autoclear;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      running && done |=> !go_r;
  endproperty : p_go_autoclear
  a_go_autoclear: assert property (p_go_autoclear) else $error("go stayed set at done");

endmodule : pcrc_top
`default_nettype wire

//--- shared/pcrc_defines.svh
// Constants for the programmable CRC generator: register map, fields, resets.
// Assumes a 32-bit classic Wishbone slave with byte addressing.
`ifndef PCRC_DEFINES_SVH
`define PCRC_DEFINES_SVH

// Word indices, compared with byte address bits 5:2
`define PCRC_OFF_CTRL1     4'h0
`define PCRC_OFF_CTRL2     4'h1
`define PCRC_OFF_XORL      4'h2
`define PCRC_OFF_XORH      4'h3
`define PCRC_OFF_DATL      4'h4
`define PCRC_OFF_DATH      4'h5
`define PCRC_OFF_RESL      4'h6
`define PCRC_OFF_RESH      4'h7
`define PCRC_OFF_IDLE      4'h8

// control_one fields
`define PCRC_C1_ON         15
`define PCRC_C1_IDLE       13
`define PCRC_C1_VW_HI      12
`define PCRC_C1_VW_LO      8
`define PCRC_C1_FULL       7
`define PCRC_C1_EMPTY      6
`define PCRC_C1_ISEL       5
`define PCRC_C1_GO         4
`define PCRC_C1_LSB        3
// control_two fields
`define PCRC_C2_DW_HI      12
`define PCRC_C2_DW_LO      8
`define PCRC_C2_PL_HI      4
`define PCRC_C2_PL_LO      0

// Depth thresholds of data_width_sel
`define PCRC_DW_WIDE       5'h0f
`define PCRC_DW_MID        5'h07
`define PCRC_DEPTH_WIDE    5'h04
`define PCRC_DEPTH_MID     5'h08
`define PCRC_DEPTH_NARROW  5'h10
`define PCRC_FIFO_WORDS    16
`define PCRC_PTR_W         4

`define PCRC_ZERO16        16'h0000
`define PCRC_ZERO32        32'h0000_0000
`define PCRC_XORL_MASK     16'hfffe

`endif

//--- shared/pcrc_pkg.sv
// Types shared by the programmable CRC generator.
// Constants live in pcrc_defines.svh.
package pcrc_pkg;

  typedef enum logic [1:0] {
    PCRC_IDLE,
    PCRC_LOAD,
    PCRC_SHIFT
  } pcrc_state_t;

  typedef struct packed {
    logic [4:0] data_width_sel;
    logic [4:0] poly_length_sel;
    logic       lsb_first_sel;
    logic       irq_cond_sel;
    logic       idle_halt;
  } pcrc_cfg_t;

endpackage : pcrc_pkg

//--- sim/testbench.sv
// Self-checking bench for the programmable CRC generator.
// Assumes pcrc_top answers a Wishbone request with ack one cycle later.
`timescale 1ns/1ps
`default_nettype none
`include "pcrc_defines.svh"

module testbench;
  logic        ref_clk  = 1'b0;
  logic        rst_n    = 1'b0;
  logic        wb_cyc   = 1'b0;
  logic        wb_stb   = 1'b0;
  logic        wb_we    = 1'b0;
  logic [5:0]  wb_adr   = 6'h00;
  logic [3:0]  wb_sel   = 4'h0;
  logic [31:0] wb_dat   = 32'h0000_0000;
  logic [31:0] rd_dat;
  logic        wb_ack;
  logic        sys_idle = 1'b0;
  logic        irq;
  int          fail_count = 0;
  int          checks     = 0;
  int          irq_seen   = 0;
  logic [15:0] rv;
  logic [15:0] exp_crc;
  logic [7:0]  msg [4] = '{8'h31, 8'h32, 8'h33, 8'h34};
  logic [4:0]  dws [3] = '{5'h1f, 5'h0f, 5'h07};
  logic [4:0]  dep [3] = '{5'h04, 5'h08, 5'h10};

  always #2.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (irq === 1'b1) begin
      irq_seen <= irq_seen + 1;
    end
  end

  pcrc_top dut (
    .i_ref_clk (ref_clk),
    .i_rst_n   (rst_n),
    .i_wb_cyc  (wb_cyc),
    .i_wb_stb  (wb_stb),
    .i_wb_we   (wb_we),
    .i_wb_adr  (wb_adr),
    .i_wb_sel  (wb_sel),
    .i_wb_dat  (wb_dat),
    .o_wb_dat  (rd_dat),
    .o_wb_ack  (wb_ack),
    .i_sys_idle(sys_idle),
    .o_irq     (irq)
  );

  task automatic report_and_stop;
    $display("Counts: %0d checks, %0d mismatches", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Request held until ack is sampled high, then released for a cycle
  task automatic bus(input logic we, input logic [3:0] idx, input logic [15:0] wd,
                     output logic [15:0] rdo);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= {idx, 2'b00};
    wb_sel <= 4'h3;
    wb_dat <= {16'h0000, wd};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (wb_ack !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end
    rdo = rd_dat[15:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] idx, input logic [15:0] wd);
    logic [15:0] dummy;
    bus(1'b1, idx, wd, dummy);
  endtask : wr

  task automatic rd(input logic [3:0] idx, output logic [15:0] rdo);
    bus(1'b0, idx, 16'h0000, rdo);
  endtask : rd

  // Polls go; a hung engine ends the run rather than the bench
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      rd(4'h0, rv);
      n++;
    end while (rv[4] !== 1'b0 && n < 100);
    if (rv[4] !== 1'b0) begin
      fail_count++;
      report_and_stop();
    end
  endtask : wait_done

  // Direct-form CRC-16, poly 0x1021; bit order only changes input order
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d,
                                        input logic lsb);
    logic fb;
    for (int i = 0; i < 8; i++) begin
      fb = c[15] ^ (lsb ? d[i] : d[7-i]);
      c  = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction : crc16

  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(4'h0, rv);
    check("control_one", rv, 16'h0040);
    rd(4'h1, rv);
    check("control_two", rv, 16'h0000);
    rd(4'hf, rv);
    check("unmapped", rv, 16'h0000);
    $display("Test reset values done");

    wr(4'h0, 16'h8000);
    wr(4'h1, 16'h070f);
    wr(4'h2, 16'h1021);
    wr(4'h3, 16'h0000);
    rd(4'h2, rv);
    check("poly_terms_low", rv, 16'h1020);
    exp_crc = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      wr(4'h4, {8'hab, msg[i]});
      exp_crc = crc16(exp_crc, msg[i], 1'b0);
    end
    rd(4'h0, rv);
    check("valid_word_count", rv, 16'h8400);
    wr(4'h0, 16'h8010);
    wait_done();
    rd(4'h6, rv);
    check("result_low msb", rv, exp_crc);
    rd(4'h7, rv);
    check("result_high", rv, 16'h0000);
    check("irq count-zero", 16'(irq_seen), 16'h0001);
    $display("Test msb first done");

    wr(4'h6, 16'h0000);
    wr(4'h7, 16'h0000);
    wr(4'h0, 16'ha028);
    exp_crc = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      wr(4'h4, {8'h00, msg[i]});
      exp_crc = crc16(exp_crc, msg[i], 1'b1);
    end
    // The FIFO is loaded before idle, since a halted block takes no data
    sys_idle <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wr(4'h0, 16'ha038);
    repeat (20) @(posedge ref_clk);
    rd(4'h0, rv);
    check("halted in idle", rv, 16'ha438);
    wr(4'h0, 16'ha028);
    sys_idle <= 1'b0;
    repeat (6) @(posedge ref_clk);
    check("irq software clear", 16'(irq_seen), 16'h0001);
    wr(4'h0, 16'ha038);
    wait_done();
    rd(4'h6, rv);
    check("result_low lsb", rv, exp_crc);
    check("irq shift done", 16'(irq_seen), 16'h0002);
    $display("Test lsb first and idle done");

    wr(4'h0, 16'h0000);
    rd(4'h0, rv);
    check("off control_one", rv, 16'h0040);
    rd(4'h1, rv);
    check("off control_two", rv, 16'h070f);
    rd(4'h6, rv);
    check("off result_low", rv, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      wr(4'h0, 16'h0000);
      wr(4'h0, 16'h8000);
      wr(4'h1, {3'b000, dws[k], 8'h1f});
      for (int j = 0; j <= int'(dep[k]); j++) begin
        if (dws[k] > 5'h0f) begin
          wr(4'h4, 16'h5678);
          if (j == 0) begin
            rd(4'h0, rv);
            check("low half no count", rv, 16'h8040);
          end
        end
        wr((dws[k] > 5'h0f) ? 4'h5 : 4'h4, 16'h1234);
      end
      rd(4'h0, rv);
      check("full flag", rv, 16'h8080 | {3'b000, dep[k], 8'h00});
    end
    wr(4'h0, 16'h0000);
    rd(4'h0, rv);
    check("emptied", rv, 16'h0040);
    $display("Test fifo depth and full done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
